// ===== src/ssor_consts.svh
// constants for the servo status output router: offsets, fields, resets
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef SSOR_CONSTS_SVH
`define SSOR_CONSTS_SVH

// register byte offsets
`define SSOR_OFF_SELECT 8'h00
`define SSOR_OFF_TLIMIT 8'h04
`define SSOR_OFF_TLEVEL 8'h08
`define SSOR_OFF_TTIME 8'h0C
`define SSOR_OFF_STATE 8'h10
`define SSOR_OFF_IRQ_STAT 8'h14
`define SSOR_OFF_IRQ_MASK 8'h18
`define SSOR_OFF_REMOTE 8'h1C

// reset values
`define SSOR_RST_SELECT 12'h210
`define SSOR_RST_TLIMIT 16'hFFFF
`define SSOR_RST_TLEVEL 16'hFFFF
`define SSOR_RST_TTIME 16'h0000

// selection digit width
`define SSOR_DIGIT_W 4

// event bit positions in the interrupt status and mask
`define SSOR_EV_EXCITE 0
`define SSOR_EV_TLIMIT 1
`define SSOR_EV_TDETECT 2
`define SSOR_EV_W 3

// torque detect time unit and clock period, in ns
`define SSOR_TIME_UNIT_NS 1000000
`define SSOR_CLK_PERIOD_NS 25

`endif

// ===== src/ssor_pkg.sv
// types for the servo status output router
// assumes ssor_consts.svh supplies the numeric constants
package ssor_pkg;

  // status function codes, one per selection digit value from 0 to B
  typedef enum logic [3:0] {
    SSOR_FN_IN_POSITION = 4'h0,
    SSOR_FN_ROTATION = 4'h1,
    SSOR_FN_DRIVE_READY = 4'h2,
    SSOR_FN_TORQUE_LIMITED = 4'h3,
    SSOR_FN_BRAKE = 4'h4,
    SSOR_FN_INDEX_PULSE = 4'h5,
    SSOR_FN_OVERTRAVEL = 4'h6,
    SSOR_FN_EXCITATION = 4'h7,
    SSOR_FN_HOMING_DONE = 4'h8,
    SSOR_FN_TORQUE_THRESHOLD = 4'h9,
    SSOR_FN_REMOTE_ONE = 4'hA,
    SSOR_FN_REMOTE_TWO = 4'hB
  } ssor_fn_e;

  // torque threshold qualifier states
  typedef enum logic [1:0] {
    SSOR_TD_IDLE = 2'b00,
    SSOR_TD_WAIT = 2'b01,
    SSOR_TD_ON = 2'b10
  } ssor_td_state_e;

endpackage

// ===== src/ssor_router.sv
// servo status output router: builds the excitation, torque limited and
// torque threshold flags and routes one status function to each slot
// assumes the other status sources come from logic on clk_i, and a
// classic wishbone master for the registers
`timescale 1ns/100ps
`include "ssor_consts.svh"

module ssor_router #(
  parameter int SLOTS = 3,
  parameter int TORQUE_W = 16,
  parameter int TIME_W = 16,
  parameter int TICK_CYCLES = `SSOR_TIME_UNIT_NS / `SSOR_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // drive state
  input wire logic servo_enabled_i,
  input wire logic motor_excited_i,
  input wire logic [TORQUE_W-1:0] torque_ref_i,
  input wire logic [TORQUE_W-1:0] motor_torque_i,
  // other status sources, active high meaning asserted
  input wire logic in_position_flag_i,
  input wire logic speed_match_flag_i,
  input wire logic speed_mode_i,
  input wire logic rotation_detect_flag_i,
  input wire logic drive_ready_flag_i,
  input wire logic brake_interlock_flag_i,
  input wire logic index_pulse_flag_i,
  input wire logic overtravel_flag_i,
  input wire logic homing_done_flag_i,
  // output terminal pairs, active low
  output logic [SLOTS-1:0] slot_n_o,
  // interrupt
  output logic irq_o
);

  localparam int SEL_W = SLOTS * `SSOR_DIGIT_W;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // elaboration checks
  if (SLOTS < 1 || SLOTS > 8) begin : g_bad_slots
    $error("SLOTS must lie between 1 and 8");
  end
  if (TORQUE_W < 1 || TORQUE_W > 32 || TIME_W < 1 || TIME_W > 32)
  begin : g_bad_width
    $error("TORQUE_W and TIME_W must lie between 1 and 32");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // registers
  logic [SEL_W-1:0] select_reg;
  logic [TORQUE_W-1:0] tlimit_reg;
  logic [TORQUE_W-1:0] tlevel_reg;
  logic [TIME_W-1:0] ttime_reg;
  logic [1:0] remote_reg;
  logic [`SSOR_EV_W-1:0] irq_stat_reg;
  logic [`SSOR_EV_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  // internal flags, active high meaning asserted, except slot_n_reg and slot_n_next, which are active low
  logic excite_reg;
  logic tlimit_flag_reg;
  logic tdetect;
  logic [`SSOR_EV_W-1:0] flags_now;
  logic [`SSOR_EV_W-1:0] flags_last_reg;
  logic [`SSOR_EV_W-1:0] events;
  logic [SLOTS-1:0] slot_n_reg;
  logic [SLOTS-1:0] slot_n_next;
  logic [SLOTS-1:0] slot_on;
  logic [15:0] source_vec;

  // time base divider
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;

  // wishbone decode
  logic req;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic hit_select;
  logic hit_tlimit;
  logic hit_tlevel;
  logic hit_ttime;
  logic hit_state;
  logic hit_irq_stat;
  logic hit_irq_mask;
  logic hit_remote;

  // byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // merge a write through the lane mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction

  // one selection digit to the source it names
  function automatic logic pick(input logic [3:0] code,
                                input logic [15:0] src);
    pick = src[code];
  endfunction

  // bus request and decode
  assign req = cyc_i && stb_i;
  assign wr_fire = req && we_i && ack_reg;
  assign wmask = lane_mask(sel_i);
  assign hit_select = adr_i == `SSOR_OFF_SELECT;
  assign hit_tlimit = adr_i == `SSOR_OFF_TLIMIT;
  assign hit_tlevel = adr_i == `SSOR_OFF_TLEVEL;
  assign hit_ttime = adr_i == `SSOR_OFF_TTIME;
  assign hit_state = adr_i == `SSOR_OFF_STATE;
  assign hit_irq_stat = adr_i == `SSOR_OFF_IRQ_STAT;
  assign hit_irq_mask = adr_i == `SSOR_OFF_IRQ_MASK;
  assign hit_remote = adr_i == `SSOR_OFF_REMOTE;

  // invert at slot width first, so the cast below pads with zeros
  assign slot_on = ~slot_n_reg;

  // unmapped addresses are acked and read as zero
  assign rd_mux =
    hit_select ? 32'(select_reg) :
    hit_tlimit ? 32'(tlimit_reg) :
    hit_tlevel ? 32'(tlevel_reg) :
    hit_ttime ? 32'(ttime_reg) :
    hit_state ? {16'h0000, 8'(slot_on), 5'h00, flags_now} :
    hit_irq_stat ? 32'(irq_stat_reg) :
    hit_irq_mask ? 32'(irq_mask_reg) :
    hit_remote ? 32'(remote_reg) :
    32'h0000_0000;

  // ack one cycle after the request, dropped in the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rd_mux;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // software registers, written at the edge where ack is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_reg <= SEL_W'(`SSOR_RST_SELECT);
      tlimit_reg <= TORQUE_W'(`SSOR_RST_TLIMIT);
      tlevel_reg <= TORQUE_W'(`SSOR_RST_TLEVEL);
      ttime_reg <= TIME_W'(`SSOR_RST_TTIME);
      remote_reg <= 2'h0;
      irq_mask_reg <= '0;
    end else if (wr_fire) begin
      if (hit_select) begin
        select_reg <= SEL_W'(merge(32'(select_reg), dat_i, wmask));
      end
      if (hit_tlimit) begin
        tlimit_reg <= TORQUE_W'(merge(32'(tlimit_reg), dat_i, wmask));
      end
      if (hit_tlevel) begin
        tlevel_reg <= TORQUE_W'(merge(32'(tlevel_reg), dat_i, wmask));
      end
      if (hit_ttime) begin
        ttime_reg <= TIME_W'(merge(32'(ttime_reg), dat_i, wmask));
      end
      if (hit_remote) begin
        remote_reg <= 2'(merge(32'(remote_reg), dat_i, wmask));
      end
      if (hit_irq_mask) begin
        irq_mask_reg <= `SSOR_EV_W'(merge(32'(irq_mask_reg), dat_i, wmask));
      end
    end
  end

  // time unit tick for the torque detect time
  assign tick = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // drive flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      excite_reg <= 1'b0;
      tlimit_flag_reg <= 1'b0;
    end else begin
      excite_reg <= servo_enabled_i && motor_excited_i;
      // equal reference and limit leaves the flag as it was
      if (torque_ref_i > tlimit_reg) begin
        tlimit_flag_reg <= 1'b1;
      end else if (torque_ref_i < tlimit_reg) begin
        tlimit_flag_reg <= 1'b0;
      end
    end
  end

  ssor_torque_detect #(
    .TORQUE_W(TORQUE_W),
    .TIME_W(TIME_W)
  ) u_tdetect (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .torque_i(motor_torque_i),
    .level_i(tlevel_reg),
    .time_i(ttime_reg),
    .detect_o(tdetect)
  );

  // events: each flag turning on
  assign flags_now[`SSOR_EV_EXCITE] = excite_reg;
  assign flags_now[`SSOR_EV_TLIMIT] = tlimit_flag_reg;
  assign flags_now[`SSOR_EV_TDETECT] = tdetect;
  assign events = flags_now & ~flags_last_reg;

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_last_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      flags_last_reg <= flags_now;
      if (wr_fire && hit_irq_stat) begin
        irq_stat_reg <= (irq_stat_reg & ~`SSOR_EV_W'(dat_i & wmask))
                        | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // status sources indexed by function code, codes C to F stay off
  // in-position in position mode, speed match in speed mode
  assign source_vec = {
    4'h0,
    remote_reg[1],
    remote_reg[0],
    tdetect,
    homing_done_flag_i,
    excite_reg,
    overtravel_flag_i,
    index_pulse_flag_i,
    brake_interlock_flag_i,
    tlimit_flag_reg,
    drive_ready_flag_i,
    rotation_detect_flag_i,
    speed_mode_i ? speed_match_flag_i : in_position_flag_i
  };

  // per-slot selection; outputs are active low
  genvar s;
  generate
    for (s = 0; s < SLOTS; s = s + 1) begin : g_slot
      assign slot_n_next[s] =
        !pick(select_reg[s*`SSOR_DIGIT_W +: `SSOR_DIGIT_W], source_vec);
    end
  endgenerate

  // registered slots: no glitches while the selection is stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_n_reg <= '1;
    end else begin
      slot_n_reg <= slot_n_next;
    end
  end

  assign slot_n_o = slot_n_reg;

endmodule // ssor_router

// ===== src/ssor_torque_detect.sv
// torque threshold qualifier: the flag rises once torque has stayed
// above the detection level for the detection time, falls at once at or below
// assumes a one-cycle time tick from the parent's divider
`timescale 1ns/100ps
`include "ssor_consts.svh"

module ssor_torque_detect #(
  parameter int TORQUE_W = 16,
  parameter int TIME_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // time base
  input wire logic tick_i,
  // torque and settings
  input wire logic [TORQUE_W-1:0] torque_i,
  input wire logic [TORQUE_W-1:0] level_i,
  input wire logic [TIME_W-1:0] time_i,
  // qualified flag, active high
  output logic detect_o
);

  ssor_pkg::ssor_td_state_e state_reg;
  ssor_pkg::ssor_td_state_e state_next;
  logic [TIME_W-1:0] count_reg;
  logic [TIME_W-1:0] count_next;
  logic above;
  logic timed_out;

  assign above = torque_i > level_i;
  assign timed_out = count_reg >= time_i;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ssor_pkg::SSOR_TD_IDLE: begin
        count_next = '0;
        if (above) begin
          state_next = ssor_pkg::SSOR_TD_WAIT;
        end
      end
      ssor_pkg::SSOR_TD_WAIT: begin
        // a zero time setting qualifies on the next cycle
        if (!above) begin
          state_next = ssor_pkg::SSOR_TD_IDLE;
        end else if (timed_out) begin
          state_next = ssor_pkg::SSOR_TD_ON;
        end else if (tick_i) begin
          count_next = count_reg + 1'b1;
        end
      end
      ssor_pkg::SSOR_TD_ON: begin
        if (!above) begin
          state_next = ssor_pkg::SSOR_TD_IDLE;
        end
      end
      default: begin
        state_next = ssor_pkg::SSOR_TD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ssor_pkg::SSOR_TD_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign detect_o = state_reg == ssor_pkg::SSOR_TD_ON;

endmodule // ssor_torque_detect

// ===== test/servo_status_output_router_tb.sv
// bench for the status router: registers, codes, routing, flags, irq
// assumes a wishbone master and a host card reading the slots
`timescale 1ns/100ps
`include "ssor_consts.svh"
module servo_status_output_router_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic en = 1'b0;
  logic ex = 1'b0;
  logic smode = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [15:0] tref = 16'h0;
  logic [15:0] tmot = 16'h0;
  logic [7:0] src = 8'h00;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [2:0] slot_n;
  logic [2:0] seen;
  int err_total = 0;
  int check_count = 0;
  int cyc_cnt = 0;
  always #12.5 clk_i = ~clk_i;
  // short tick keeps detection times to a few cycles
  ssor_router #(.TICK_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .servo_enabled_i(en), .motor_excited_i(ex), .torque_ref_i(tref),
    .motor_torque_i(tmot), .in_position_flag_i(src[0]),
    .speed_match_flag_i(src[1]), .speed_mode_i(smode),
    .rotation_detect_flag_i(src[2]), .drive_ready_flag_i(src[3]),
    .brake_interlock_flag_i(src[4]), .index_pulse_flag_i(src[5]),
    .overtravel_flag_i(src[6]), .homing_done_flag_i(src[7]),
    .slot_n_o(slot_n), .irq_o(irq));
  ssor_host_model host (.clk_i(clk_i), .slot_n_i(slot_n), .seen_on_o(seen));
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check($sformatf("reg %h", a), e, q);
  endtask
  task automatic slots(int n, logic [2:0] e);
    repeat (n) @(posedge clk_i);
    check("slots on", {29'h0, e}, {29'h0, seen});
  endtask
  task automatic t_reset();
    logic [31:0] rv [9] = '{32'h210, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) rd(8'(i * 4), rv[i]);
    en <= 1'b1;
    ex <= 1'b1;
    slots(6, 3'h0);
  endtask
  task automatic t_codes();
    logic on;
    wr(`SSOR_OFF_TLIMIT, 32'h100);
    wr(`SSOR_OFF_TLEVEL, 32'h100);
    for (int p = 0; p < 2; p++) begin
      on = p == 0;
      src <= {8{on}};
      en <= on;
      ex <= on;
      tref <= on ? 16'h200 : 16'h0;
      tmot <= on ? 16'h200 : 16'h0;
      wr(`SSOR_OFF_REMOTE, on ? 32'h3 : 32'h0);
      for (int c = 0; c < 16; c++) begin
        wr(`SSOR_OFF_SELECT, {20'h0, 4'(c), 4'(c), 4'(c)});
        slots(6, (on && c < 12) ? 3'h7 : 3'h0);
      end
    end
  endtask
  task automatic t_route();
    tref <= 16'h200;
    for (int k = 0; k < 3; k++) begin
      wr(`SSOR_OFF_SELECT, 32'hFFF ^ (32'hC << (4 * k)));
      slots(6, 3'(1 << k));
    end
    tref <= 16'h100;
    slots(6, 3'h4);
    tref <= 16'h0FF;
    slots(6, 3'h0);
    // code 0 follows in-position or speed match by mode
    src <= 8'h01;
    wr(`SSOR_OFF_SELECT, 32'h0);
    slots(6, 3'h7);
    smode <= 1'b1;
    slots(6, 3'h0);
    src <= 8'h02;
    slots(6, 3'h7);
    smode <= 1'b0;
    src <= 8'h00;
    slots(6, 3'h0);
  endtask
  task automatic t_excite();
    wr(`SSOR_OFF_SELECT, 32'h777);
    wr(`SSOR_OFF_IRQ_STAT, 32'h7);
    wr(`SSOR_OFF_IRQ_MASK, 32'h1);
    en <= 1'b1;
    slots(6, 3'h0);
    ex <= 1'b1;
    slots(6, 3'h7);
    check("irq", 32'h1, {31'h0, irq});
    rd(`SSOR_OFF_STATE, 32'h701);
    rd(`SSOR_OFF_IRQ_STAT, 32'h1);
    wr(`SSOR_OFF_IRQ_STAT, 32'h1);
    check("irq", 32'h0, {31'h0, irq});
    en <= 1'b0;
    slots(6, 3'h0);
    wr(`SSOR_OFF_IRQ_MASK, 32'h0);
    en <= 1'b1;
    slots(6, 3'h7);
    check("irq", 32'h0, {31'h0, irq});
    rd(`SSOR_OFF_IRQ_STAT, 32'h1);
  endtask
  task automatic t_thr();
    wr(`SSOR_OFF_SELECT, 32'h999);
    wr(`SSOR_OFF_TTIME, 32'h3);
    tmot <= 16'h100;
    slots(6, 3'h0);
    tmot <= 16'h101;
    slots(5, 3'h0);
    slots(16, 3'h7);
    tmot <= 16'h0FF;
    slots(4, 3'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_codes();
    t_route();
    t_excite();
    t_thr();
    print_verdict();
  end
endmodule // servo_status_output_router_tb

// ===== test/ssor_host_model.sv
// host controller model: an input card reading the slot terminals
// assumes active low slots, stable between clock edges
`timescale 1ns/100ps
module ssor_host_model #(
  parameter int SLOTS = 3
) (
  // clock
  input wire logic clk_i,
  // terminal pairs from the drive
  input wire logic [SLOTS-1:0] slot_n_i,
  // card view, active high
  output logic [SLOTS-1:0] seen_on_o
);
  // one latch per cycle; no input filter, so glitches would show
  always_ff @(posedge clk_i) begin
    seen_on_o <= ~slot_n_i;
  end
endmodule // ssor_host_model

// ===== test/ssor_router_chk.sv
// checker for the status router: bus answer, flag routing, bad codes
// assumes binding to ssor_router and full-word register writes
`timescale 1ns/100ps
`include "ssor_consts.svh"
module ssor_router_chk #(
  parameter int SLOTS = 3,
  parameter int TORQUE_W = 16
) (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // drive state and slots
  input wire logic servo_enabled_i,
  input wire logic motor_excited_i,
  input wire logic [TORQUE_W-1:0] torque_ref_i,
  input wire logic [TORQUE_W-1:0] motor_torque_i,
  input wire logic [SLOTS-1:0] slot_n_o
);
  logic [15:0] sel_q;
  logic [15:0] lim_q;
  logic [15:0] lvl_q;
  logic [1:0] age_q;
  // settings shadowed here since only the ports are visible
  wire wr_w = cyc_i && stb_i && we_i && ack_o;
  wire ok_w = age_q == 2'h3;
  wire [3:0] d0_w = sel_q[3:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= 16'h0210;
      lim_q <= 16'hFFFF;
      lvl_q <= 16'hFFFF;
      age_q <= 2'h0;
    end else begin
      if (wr_w && adr_i == `SSOR_OFF_SELECT) sel_q <= dat_i[15:0];
      if (wr_w && adr_i == `SSOR_OFF_TLIMIT) lim_q <= dat_i[15:0];
      if (wr_w && adr_i == `SSOR_OFF_TLEVEL) lvl_q <= dat_i[15:0];
      age_q <= wr_w ? 2'h0 : (ok_w ? age_q : age_q + 2'h1);
    end
  end
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  excite_route_a: assert property (ok_w && d0_w == 4'h7 |->
    slot_n_o[0] == !$past(servo_enabled_i && motor_excited_i, 2))
    else $error("excitation slot wrong");
  limit_on_a: assert property (ok_w && d0_w == 4'h3 &&
    $past(torque_ref_i, 2) > lim_q |-> !slot_n_o[0])
    else $error("torque limited slot not on");
  limit_off_a: assert property (ok_w && d0_w == 4'h3 &&
    $past(torque_ref_i, 2) < lim_q |-> slot_n_o[0])
    else $error("torque limited slot not off");
  thr_off_a: assert property (ok_w && d0_w == 4'h9 &&
    $past(motor_torque_i, 2) <= lvl_q |-> slot_n_o[0])
    else $error("torque threshold slot not off");
  bad_code_a: assert property (ok_w && sel_q[11:8] > 4'hB |->
    slot_n_o[2]) else $error("unused code drives slot");
  unmapped_zero_a: assert property (ack_o && !we_i && adr_i > 8'h1C
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  cover property (ok_w && d0_w == 4'h9 && !slot_n_o[0]);
  cover property (ok_w && d0_w == 4'h3 && !slot_n_o[0]);
  cover property (ack_o && we_i);
endmodule // ssor_router_chk

bind ssor_router ssor_router_chk #(.SLOTS(SLOTS), .TORQUE_W(TORQUE_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .servo_enabled_i(servo_enabled_i), .motor_excited_i(motor_excited_i),
  .torque_ref_i(torque_ref_i), .motor_torque_i(motor_torque_i),
  .slot_n_o(slot_n_o));
